// >>> shared/icv_pkg.sv
// Constants shared by the vectored interrupt controller files
package icv_pkg;
    // ------------------------------------------------------------
    // Register location and layout
    // ------------------------------------------------------------
    localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h0b;
    localparam logic [7:0] INTERRUPT_CONTROL_RST  = 8'h00;
    localparam int         MASTER_BIT             = 0;
    localparam int         ENABLE_LSB             = 1;
    localparam int         FLAG_LSB               = 4;
    localparam int         UNUSED_BIT             = 7;
    localparam int         NUM_SRC                = 3;

    // ------------------------------------------------------------
    // Source indices, lowest index has highest priority
    // ------------------------------------------------------------
    localparam int SRC_EXT  = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_TMR1 = 2;

    // ------------------------------------------------------------
    // Program counter, vectors and return stack
    // ------------------------------------------------------------
    localparam int              PC_W        = 12;
    localparam logic [PC_W-1:0] VEC_EXT     = 12'h004;
    localparam logic [PC_W-1:0] VEC_TMR0    = 12'h008;
    localparam logic [PC_W-1:0] VEC_TMR1    = 12'h00c;
    localparam logic [PC_W-1:0] PC_RST      = 12'h000;
    localparam int              STACK_DEPTH = 6;
endpackage : icv_pkg

// >>> src/icv_ret_stack.sv
// Return address stack with registered pop data
module icv_ret_stack #(
    parameter int DEPTH = icv_pkg::STACK_DEPTH,
    parameter int WIDTH = icv_pkg::PC_W
) (
    input  wire logic             clk,       // System clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             push,      // Store push_data
    input  wire logic [WIDTH-1:0] push_data, // Address to save
    input  wire logic             pop,       // Retrieve newest entry
    output logic      [WIDTH-1:0] pop_data,  // Popped address, next cycle
    output logic                  full       // All levels in use
);
    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] DEPTH_C = PW'(DEPTH);
    localparam logic [PW-1:0] LAST_C  = PW'(DEPTH - 1);
    localparam logic [PW-1:0] ONE_C   = PW'(1);

    if (DEPTH < 2) begin : g_bad_depth
        $error("icv_ret_stack: DEPTH must be at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    count;
    logic [PW-1:0]    top;

    assign full = (count == DEPTH_C);
    assign top  = (wptr == '0) ? LAST_C : wptr - ONE_C;

    // ------------------------------------------------------------
    // Circular storage: a push when full drops the oldest entry
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr  <= '0;
            count <= '0;
        end else if (push) begin
            wptr  <= (wptr == LAST_C) ? '0 : wptr + ONE_C;
            count <= full ? count : count + ONE_C;
        end else if (pop && count != '0) begin
            wptr  <= top;
            count <= count - ONE_C;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pop_data <= '0;
        end else if (pop && !push && count != '0) begin
            pop_data <= mem[top];
        end
    end
endmodule : icv_ret_stack

// >>> src/icv_irq_ctrl.sv
// Three source vectored interrupt controller with return stack
module icv_irq_ctrl #(
    parameter int STACK_DEPTH = icv_pkg::STACK_DEPTH
) (
    input  wire logic                     clk,             // System clock
    input  wire logic                     rst_n,           // Async reset, active low
    input  wire logic [7:0]               mem_addr,        // Data memory address
    input  wire logic                     mem_wr,          // Data memory write strobe
    input  wire logic                     mem_rd,          // Data memory read strobe
    input  wire logic [7:0]               mem_wdata,       // Write data
    output logic      [7:0]               mem_rdata,       // Read data, next cycle
    input  wire logic                     ext_irq_pin,     // External interrupt pin
    input  wire logic                     tmr0_overflow,   // Timer 0 overflow pulse
    input  wire logic                     tmr1_overflow,   // Timer 1 overflow pulse
    input  wire logic                     phase_two_pulse, // Second phase of cycle
    input  wire logic [icv_pkg::PC_W-1:0] pc_now,          // Address to save
    input  wire logic                     call_push,       // Subroutine call
    input  wire logic                     return_plain,    // Plain return
    input  wire logic                     return_from_irq, // Interrupt return
    input  wire logic                     power_down,      // Core halted, level
    output logic                          irq_ack,         // Acknowledge pulse
    output logic      [icv_pkg::PC_W-1:0] irq_vector,      // Branch target
    output logic      [icv_pkg::PC_W-1:0] ret_pc,          // Popped address
    output logic                          stack_full,      // Stack levels used up
    output logic                          wake_up,         // Wake-up pulse
    output logic                          wake_no_vector   // Wake resumes in line
);
    localparam int N = icv_pkg::NUM_SRC;

    if (STACK_DEPTH < 2) begin : g_bad_depth
        $error("icv_irq_ctrl: STACK_DEPTH must be at least 2");
    end

    logic         ext_sync0;
    logic         ext_sync1;
    logic         ext_prev;
    logic [N-1:0] src_evt;
    logic [N-1:0] flags;
    logic [N-1:0] enables;
    logic         master_irq_enable;
    logic [N-1:0] pending;
    logic [N-1:0] grant;
    logic         do_ack;
    logic         stack_op;
    logic         reg_hit;
    logic         reg_wr;
    logic [7:0]   ctrl_value;
    logic [icv_pkg::PC_W-1:0] next_vector;
    logic         pd_prev;
    logic [N-1:0] wake_armed;
    logic [N-1:0] wake_src;

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync0 <= 1'b0;
            ext_sync1 <= 1'b0;
            ext_prev  <= 1'b0;
        end else begin
            ext_sync0 <= ext_irq_pin;
            ext_sync1 <= ext_sync0;
            ext_prev  <= ext_sync1;
        end
    end

    assign src_evt[icv_pkg::SRC_EXT]  = ext_sync1 ^ ext_prev;
    assign src_evt[icv_pkg::SRC_TMR0] = tmr0_overflow;
    assign src_evt[icv_pkg::SRC_TMR1] = tmr1_overflow;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    assign reg_hit    = (mem_addr == icv_pkg::INTERRUPT_CONTROL_ADDR);
    assign reg_wr     = mem_wr && reg_hit;
    assign ctrl_value = {1'b0, flags, enables, master_irq_enable};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rdata <= icv_pkg::INTERRUPT_CONTROL_RST;
        end else if (mem_rd && reg_hit) begin
            mem_rdata <= ctrl_value;
        end else begin
            mem_rdata <= 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enables <= '0;
        end else if (reg_wr) begin
            enables <= mem_wdata[icv_pkg::ENABLE_LSB +: N];
        end
    end

    // Software write wins over acknowledge clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_irq_enable <= 1'b0;
        end else if (reg_wr) begin
            master_irq_enable <= mem_wdata[icv_pkg::MASTER_BIT];
        end else if (do_ack) begin
            master_irq_enable <= 1'b0;
        end else if (return_from_irq) begin
            master_irq_enable <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Request flags: a new event beats any clear
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags[i] <= 1'b0;
            end else if (src_evt[i]) begin
                flags[i] <= 1'b1;
            end else if (reg_wr) begin
                flags[i] <= mem_wdata[icv_pkg::FLAG_LSB + i];
            end else if (do_ack && grant[i]) begin
                flags[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Arbitration and acknowledge
    // ------------------------------------------------------------
    assign pending  = flags & enables & {N{master_irq_enable}};
    assign grant    = pending & (~pending + N'(1));
    assign stack_op = call_push || return_plain || return_from_irq;
    // Only at phase two, never with another stack operation
    assign do_ack   = phase_two_pulse && (|pending) && !stack_full
                   && !stack_op;

    always_comb begin
        next_vector = icv_pkg::VEC_TMR1;
        if (grant[icv_pkg::SRC_EXT]) begin
            next_vector = icv_pkg::VEC_EXT;
        end else if (grant[icv_pkg::SRC_TMR0]) begin
            next_vector = icv_pkg::VEC_TMR0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack    <= 1'b0;
            irq_vector <= icv_pkg::PC_RST;
        end else begin
            irq_ack <= do_ack;
            if (do_ack) begin
                irq_vector <= next_vector;
            end
        end
    end

    // ------------------------------------------------------------
    // Return stack shared by calls and acknowledges
    // ------------------------------------------------------------
    icv_ret_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (icv_pkg::PC_W)
    ) u_stack (
        .clk       (clk),
        .rst_n     (rst_n),
        .push      (call_push || do_ack),
        .push_data (pc_now),
        .pop       (return_plain || return_from_irq),
        .pop_data  (ret_pc),
        .full      (stack_full)
    );

    // ------------------------------------------------------------
    // Wake-up from power-down
    // ------------------------------------------------------------
    assign wake_src = src_evt & wake_armed;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_prev    <= 1'b0;
            wake_armed <= '0;
        end else begin
            pd_prev <= power_down;
            if (power_down && !pd_prev) begin
                wake_armed <= ~flags;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_up        <= 1'b0;
            wake_no_vector <= 1'b0;
        end else begin
            wake_up        <= power_down && pd_prev && (|wake_src);
            wake_no_vector <= power_down && pd_prev && (|wake_src)
                           && (!master_irq_enable || !(|(wake_src & enables))
                               || stack_full);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ack_on_phase: assert property (irq_ack |-> $past(phase_two_pulse))
        else $error("acknowledge outside phase two");
    a_ack_not_full: assert property (irq_ack |-> !$past(stack_full))
        else $error("acknowledge while stack full");
    a_ack_masked: assert property (!master_irq_enable |=> !irq_ack)
        else $error("acknowledge with master disabled");
    a_ack_clears_master: assert property (do_ack && !reg_wr |=> !master_irq_enable)
        else $error("master not cleared on acknowledge");
    a_ext_first: assert property (do_ack && pending[0] |=> irq_vector == icv_pkg::VEC_EXT)
        else $error("external not served first");
    a_tmr0_over_tmr1: assert property (do_ack && !pending[0] && pending[1]
                                       |=> irq_vector == icv_pkg::VEC_TMR0)
        else $error("timer 0 not served before timer 1");
    a_tmr0_vector: assert property (do_ack && pending == 3'b010 && !tmr0_overflow && !reg_wr
                                    |=> irq_vector == icv_pkg::VEC_TMR0 ##0 !flags[1])
        else $error("timer 0 vector or flag wrong");
    a_tmr1_vector: assert property (do_ack && pending == 3'b100
                                    |=> irq_vector == icv_pkg::VEC_TMR1)
        else $error("timer 1 vector wrong");
    a_ext_clears_flag: assert property (do_ack && grant[0] && !src_evt[0] && !reg_wr
                                        |=> !flags[0])
        else $error("external flag not cleared on acknowledge");
    a_tmr1_clears_flag: assert property (do_ack && grant[2] && !src_evt[2] && !reg_wr
                                         |=> !flags[2])
        else $error("timer 1 flag not cleared on acknowledge");
    a_edge_sets_flag: assert property ($changed(ext_sync1) |=> ##1 flags[0] || $past(do_ack)
                                       || $past(reg_wr))
        else $error("pin edge lost");
    a_tmr0_sets_flag: assert property (tmr0_overflow |=> flags[1])
        else $error("timer 0 overflow lost");
    a_tmr_sets_flag: assert property (tmr1_overflow |=> flags[2])
        else $error("timer 1 overflow lost");
    a_masked_records: assert property (!master_irq_enable && tmr0_overflow |=> flags[1])
        else $error("masked request not recorded");
    a_flag_holds: assert property ($fell(flags[1]) |-> $past(reg_wr || do_ack))
        else $error("flag dropped without cause");
    a_sw_flag_write: assert property (reg_wr && !(|src_evt)
                                      |=> flags == $past(mem_wdata[icv_pkg::FLAG_LSB +: N]))
        else $error("flag write not applied");
    a_enable_write: assert property (reg_wr
                                     |=> enables == $past(mem_wdata[icv_pkg::ENABLE_LSB +: N]))
        else $error("enable write not applied");
    a_bit7_zero: assert property (!mem_rdata[icv_pkg::UNUSED_BIT])
        else $error("unused bit reads one");
    a_return_from_irq_master: assert property (return_from_irq && !reg_wr |=> master_irq_enable)
        else $error("interrupt return left master clear");
    a_ret_master: assert property (return_plain && !reg_wr && !do_ack
                                   |=> $stable(master_irq_enable))
        else $error("plain return changed master");
    a_ack_soon: assert property (pending != '0 && !stack_full && !stack_op
                                 && phase_two_pulse |-> ##1 irq_ack)
        else $error("enabled request not acknowledged");
    a_vector_holds: assert property (!do_ack |=> $stable(irq_vector))
        else $error("vector changed without acknowledge");
    a_wake_pd: assert property (wake_up |-> $past(power_down, 2))
        else $error("wake-up outside power-down");
    a_wake_arm: assert property ($rose(power_down) |=> (wake_armed & $past(flags)) == '0)
        else $error("source with set flag armed for wake-up");
    a_wake_full_inline: assert property (wake_up && $past(stack_full) |-> wake_no_vector)
        else $error("wake-up vectors with stack full");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_ext_ack: cover property (do_ack && grant[0]);
    c_nested: cover property (irq_ack ##[1:50] irq_ack);
    c_full_wait: cover property (stack_full && pending != '0 && phase_two_pulse);
    c_wake: cover property (wake_up && !wake_no_vector);
    c_wake_vector: cover property (wake_up && !wake_no_vector ##[1:8] irq_ack);
endmodule : icv_irq_ctrl

// >>> dv/icv_seq_model.sv
// Core sequencer model that issues the phase two pulse
module icv_seq_model (
    input  wire logic clk,             // System clock
    input  wire logic rst_n,           // Async reset, active low
    output logic      phase_two_pulse  // Second phase of each cycle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase;

    // ------------------------------------------------------------
    // Four phases per instruction cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign phase_two_pulse = (phase == 2'h1);
endmodule : icv_seq_model

// >>> dv/three_source_vectored_irq_tb.sv
// Self-checking bench for the vectored interrupt controller
module three_source_vectored_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, mem_wr, mem_rd, ext_irq_pin, tmr0_overflow, tmr1_overflow;
    logic        call_push, return_plain, return_from_irq, power_down, phase_two_pulse;
    logic [7:0]  mem_addr, mem_wdata, mem_rdata;
    logic [11:0] pc_now, irq_vector, ret_pc, p1, p2, p3;
    logic        irq_ack, stack_full, wake_up, wake_no_vector;
    logic        rd_d, ret_d, ph_d;
    logic [15:0] exp_q[$];
    int          miscompares, n_tests, cycles, seed;

    icv_irq_ctrl dut_u (.clk(clk), .rst_n(rst_n), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .ext_irq_pin(ext_irq_pin), .tmr0_overflow(tmr0_overflow),
        .tmr1_overflow(tmr1_overflow), .phase_two_pulse(phase_two_pulse), .pc_now(pc_now),
        .call_push(call_push), .return_plain(return_plain), .return_from_irq(return_from_irq),
        .power_down(power_down), .irq_ack(irq_ack), .irq_vector(irq_vector), .ret_pc(ret_pc),
        .stack_full(stack_full), .wake_up(wake_up), .wake_no_vector(wake_no_vector));

    icv_seq_model seq_u (.clk(clk), .rst_n(rst_n), .phase_two_pulse(phase_two_pulse));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task check_ev(input logic [15:0] got);
        logic [15:0] e;
        n_tests++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
        if (e !== got) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, e, got);
        end
    endtask : check_ev

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task wr(input logic [7:0] a, input logic [7:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        cyc(1);
        mem_wr = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({8'h00, e});
        mem_addr = a;
        mem_rd = 1'b1;
        cyc(1);
        mem_rd = 1'b0;
        cyc(1);
    endtask : rd

    // One-cycle pulse, then a quiet cycle so no strobe toggles twice at once
    task pulse(input int sel);
        case (sel)
            0: tmr0_overflow = 1'b1;
            1: tmr1_overflow = 1'b1;
            2: call_push = 1'b1;
            3: return_plain = 1'b1;
            default: return_from_irq = 1'b1;
        endcase
        cyc(1);
        {tmr0_overflow, tmr1_overflow, call_push, return_plain, return_from_irq} = 5'h00;
        cyc(1);
    endtask : pulse

    task wait_ack;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (irq_ack === 1'b1) break;
        end
        cyc(1);
    endtask : wait_ack

    // ------------------------------------------------------------
    // Clock, timeout and output monitor
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end

    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            if (irq_ack === 1'b1) begin
                n_tests++;
                if (ph_d !== 1'b1) begin
                    miscompares++;
                    $display("Error at %0t: expected %h got %h", $time, 1'b1, ph_d);
                end
                check_ev({4'h1, irq_vector});
            end
            if (rd_d) check_ev({8'h00, mem_rdata});
            if (ret_d) check_ev({4'h2, ret_pc});
            if (wake_up === 1'b1) check_ev({15'h3000, wake_no_vector});
        end
        ph_d = phase_two_pulse;
        rd_d = mem_rd;
        ret_d = return_plain | return_from_irq;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, mem_wr, mem_rd, ext_irq_pin, tmr0_overflow, tmr1_overflow} = 6'h00;
        {call_push, return_plain, return_from_irq, power_down} = 4'h0;
        {mem_addr, mem_wdata} = 16'h0000;
        {rd_d, ret_d, ph_d} = 3'h0;
        seed = 13;
        pc_now = 12'($random(seed));
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h00);
        ext_irq_pin = 1'b1;
        pulse(0);
        pulse(1);
        cyc(2);
        rd(8'h0b, 8'h70);
        wr(8'h0b, 8'h00);
        cyc(4);
        rd(8'h0b, 8'h00);
        ext_irq_pin = 1'b0;
        cyc(4);
        rd(8'h0b, 8'h10);
        wr(8'h0b, 8'hfe);
        cyc(8);
        rd(8'h0b, 8'h7e);
        p1 = 12'($random(seed));
        pc_now = p1;
        exp_q.push_back({4'h1, icv_pkg::VEC_EXT});
        wr(8'h0b, 8'h7f);
        wait_ack();
        rd(8'h0b, 8'h6e);
        p2 = 12'($random(seed));
        pc_now = p2;
        exp_q.push_back({4'h1, icv_pkg::VEC_TMR0});
        wr(8'h0b, 8'h6f);
        wait_ack();
        rd(8'h0b, 8'h4e);
        p3 = 12'($random(seed));
        pc_now = p3;
        exp_q.push_back({4'h2, p2});
        exp_q.push_back({4'h1, icv_pkg::VEC_TMR1});
        pulse(4);
        wait_ack();
        exp_q.push_back({4'h2, p3});
        pulse(3);
        rd(8'h0b, 8'h0e);
        exp_q.push_back({4'h2, p1});
        pulse(3);
        for (int i = 0; i < 6; i++) begin
            pc_now = 12'(i);
            pulse(2);
        end
        n_tests++;
        if (stack_full !== 1'b1) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, 1'b1, stack_full);
        end
        wr(8'h0b, 8'h25);
        cyc(10);
        rd(8'h0b, 8'h25);
        exp_q.push_back({4'h2, 12'h005});
        exp_q.push_back({4'h1, icv_pkg::VEC_TMR0});
        pulse(3);
        wait_ack();
        wr(8'h0b, 8'h04);
        power_down = 1'b1;
        cyc(2);
        exp_q.push_back({15'h3000, 1'b1});
        pulse(1);
        cyc(3);
        power_down = 1'b0;
        cyc(2);
        power_down = 1'b1;
        cyc(2);
        pulse(1);
        cyc(3);
        power_down = 1'b0;
        cyc(4);
        exp_q.push_back({4'h2, 12'h005});
        pulse(3);
        wr(8'h0b, 8'h09);
        power_down = 1'b1;
        cyc(2);
        exp_q.push_back({15'h3000, 1'b0});
        exp_q.push_back({4'h1, icv_pkg::VEC_TMR1});
        pulse(1);
        wait_ack();
        power_down = 1'b0;
        cyc(2);
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, 0, exp_q.size());
        end
        wrap_up();
    end
endmodule : three_source_vectored_irq_tb
